//--- core/msq_sequencer.sv
`timescale 1ns/1ps
`include "msq_regs.svh"
module msq_sequencer #(
    parameter int AW = 6,
    parameter int DEPTH = `MSQ_TABLE_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic step_res_sel_lo,
    input wire logic step_res_sel_hi,
    output msq_pkg::msq_phase_t phase_a,
    output msq_pkg::msq_phase_t phase_b,
    output msq_pkg::msq_decay_t decay_a,
    output msq_pkg::msq_decay_t decay_b,
    output logic [1:0] phase_max_scale,
    output logic table_loading
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    msq_pkg::msq_bus_req_t req;
    msq_pkg::msq_state_t state_reg;
    msq_pkg::msq_entry_t entry;
    logic [4:0] ctrl_reg;
    logic [AW-1:0] angle_reg;
    logic [AW-1:0] angle_next;
    logic [AW-1:0] load_idx_reg;
    logic [AW-1:0] tbl_addr_reg;
    logic fwd_reg;
    logic step_prev_reg;
    logic step_edge;
    logic serial_mode;
    logic [1:0] res_sel;
    logic [6:0] res_inc;
    logic signed [6:0] delta;
    logic move;
    logic move_fwd;
    logic mem_wr;
    logic [AW-1:0] mem_waddr;
    logic [13:0] mem_wdata;
    logic [13:0] mem_rdata;
    logic [13:0] sine_line;
    logic [AW-1:0] out_angle_reg;
    logic chg_wr;
    logic tbl_wr;

    assign req.addr = bus_addr;
    assign req.wdata = bus_wdata;
    assign req.wr = bus_wr;
    assign req.rd = bus_rd;

    // ----------------------------------------
    // Sine profile generator
    // ----------------------------------------
    // Magnitude of a sine over one quarter, in sixteenth steps
    function automatic logic [5:0] quarter_mag(input logic [4:0] k);
        logic [5:0] m;
        m = 6'h00;
        case (k)
            5'h00: m = 6'h00;
            5'h01: m = 6'h06;
            5'h02: m = 6'h0c;
            5'h03: m = 6'h12;
            5'h04: m = 6'h18;
            5'h05: m = 6'h1e;
            5'h06: m = 6'h23;
            5'h07: m = 6'h28;
            5'h08: m = 6'h2d;
            5'h09: m = 6'h31;
            5'h0a: m = 6'h34;
            5'h0b: m = 6'h38;
            5'h0c: m = 6'h3a;
            5'h0d: m = 6'h3c;
            5'h0e: m = 6'h3e;
            5'h0f: m = 6'h3f;
            default: m = 6'h3f;
        endcase
        return m;
    endfunction : quarter_mag

    // Signed sine at a table index as direction and level
    function automatic msq_pkg::msq_phase_t sine_at(input logic [5:0] n);
        msq_pkg::msq_phase_t p;
        logic [4:0] r;
        r = {1'b0, n[3:0]};
        p.dir = ~n[5];
        if (n[4]) begin
            p.dac = quarter_mag(5'h10 - r);
        end else begin
            p.dac = quarter_mag(r);
        end
        return p;
    endfunction : sine_at

    // Phase A follows the cosine, phase B the sine; both 45 at home
    always_comb begin
        sine_line = {sine_at(load_idx_reg + 6'h10), sine_at(load_idx_reg)};
    end

    // ----------------------------------------
    // Loader state machine
    // ----------------------------------------
    // Fills every line with the sine profile after reset
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= msq_pkg::MSQ_ST_LOAD;
            load_idx_reg <= '0;
        end else begin
            case (state_reg)
                msq_pkg::MSQ_ST_LOAD: begin
                    load_idx_reg <= load_idx_reg + 6'h01; // [RULE4]
                    if (load_idx_reg == AW'(DEPTH - 1)) begin
                        state_reg <= msq_pkg::MSQ_ST_RUN;
                    end
                end
                msq_pkg::MSQ_ST_RUN: begin
                    state_reg <= msq_pkg::MSQ_ST_RUN;
                end
                default: begin
                    state_reg <= msq_pkg::MSQ_ST_LOAD;
                end
            endcase
        end
    end

    assign table_loading = (state_reg == msq_pkg::MSQ_ST_LOAD);

    // Loader owns the write port; software table writes are dropped until done
    always_comb begin
        tbl_wr = req.wr && (req.addr == `MSQ_OFF_TBL_DATA) && !table_loading;
        if (table_loading) begin
            mem_wr = 1'b1;
            mem_waddr = load_idx_reg;
            mem_wdata = sine_line; // [RULE4]
        end else begin
            mem_wr = tbl_wr;
            mem_waddr = tbl_addr_reg;
            mem_wdata = req.wdata[13:0];
        end
    end

    // ----------------------------------------
    // Phase table
    // ----------------------------------------
    // One line per sixteenth microstep, read at the angle
    msq_phase_mem #(
        .DEPTH(DEPTH),
        .AW(AW),
        .DW(14)
    ) u_mem (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(mem_wr),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .rd_addr(angle_reg), // [RULE1] [RULE12]
        .rd_data(mem_rdata)
    );

    assign entry = msq_pkg::msq_entry_t'(mem_rdata); // [RULE2]

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    // Resolution bits reset to zero, which is full step
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= `MSQ_CTRL_RESET; // [RULE6]
        end else if (req.wr && req.addr == `MSQ_OFF_CTRL) begin
            ctrl_reg <= req.wdata[4:0];
        end
    end

    assign serial_mode = ctrl_reg[`MSQ_CTRL_SERIAL];
    assign phase_max_scale =
        ctrl_reg[`MSQ_CTRL_MXI_MSB:`MSQ_CTRL_MXI_LSB]; // [RULE14]

    // Table write pointer advances so a block load is one burst
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tbl_addr_reg <= '0;
        end else if (req.wr && req.addr == `MSQ_OFF_TBL_ADDR) begin
            tbl_addr_reg <= req.wdata[AW-1:0];
        end else if (tbl_wr) begin
            tbl_addr_reg <= tbl_addr_reg + 6'h01;
        end
    end

    // ----------------------------------------
    // Step resolution
    // ----------------------------------------
    // Either source can raise a bit, so pins cannot cancel config
    always_comb begin
        res_sel[0] = step_res_sel_lo | ctrl_reg[`MSQ_CTRL_RES_LO]; // [RULE7]
        res_sel[1] = step_res_sel_hi | ctrl_reg[`MSQ_CTRL_RES_HI]; // [RULE7]
        case (res_sel)
            2'b00: res_inc = `MSQ_INC_FULL; // [RULE20] [RULE3]
            2'b01: res_inc = `MSQ_INC_HALF; // [RULE20]
            2'b10: res_inc = `MSQ_INC_QUARTER; // [RULE20]
            default: res_inc = `MSQ_INC_SIXTEENTH; // [RULE20]
        endcase
    end

    // ----------------------------------------
    // Step pulse edge detect
    // ----------------------------------------
    // Resets high so a level already high at release is no edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            step_prev_reg <= 1'b1;
        end else begin
            step_prev_reg <= step_in;
        end
    end

    assign step_edge = step_in && !step_prev_reg; // [RULE15]

    // ----------------------------------------
    // Move selection
    // ----------------------------------------
    // Serial mode ignores both step and direction pins
    always_comb begin
        chg_wr = req.wr && (req.addr == `MSQ_OFF_STEP_CHG);
        move = 1'b0;
        move_fwd = fwd_reg;
        delta = '0;
        if (serial_mode) begin // [RULE17]
            if (chg_wr) begin
                // Sign-extended value, each unit is one position
                delta = {req.wdata[5], req.wdata[5:0]}; // [RULE8] [RULE9]
                move = (req.wdata[5:0] != 6'h00); // [RULE11]
                move_fwd = !req.wdata[5]; // [RULE8]
            end
        end else if (step_edge) begin
            move = 1'b1;
            move_fwd = dir_in; // [RULE16]
            if (dir_in) begin
                delta = res_inc; // [RULE5]
            end else begin
                delta = -res_inc; // [RULE5] [RULE16]
            end
        end
    end

    // Host range of plus or minus sixteen is not enforced here
    msq_angle_add #(
        .AW(AW),
        .DW(7)
    ) u_add (
        .angle(angle_reg),
        .delta(delta), // [RULE10]
        .sum(angle_next)
    );

    // ----------------------------------------
    // Angle and motion direction
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            angle_reg <= `MSQ_HOME_ANGLE; // [RULE4]
            fwd_reg <= 1'b1;
        end else if (move) begin
            angle_reg <= angle_next; // [RULE19]
            fwd_reg <= move_fwd;
        end
    end

    // Angle delayed to line up with the registered table read
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            out_angle_reg <= `MSQ_HOME_ANGLE;
        end else begin
            out_angle_reg <= angle_reg;
        end
    end

    // ----------------------------------------
    // Phase drive and decay
    // ----------------------------------------
    // Level passes unscaled; 63 is full phase maximum in the DAC
    assign phase_a = entry.a; // [RULE12] [RULE18]
    assign phase_b = entry.b; // [RULE12] [RULE18]

    // Sine magnitude rises in even quadrants when moving forward;
    // cosine the other way. Rising uses slow decay, falling mixed.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            decay_a <= msq_pkg::MSQ_DECAY_SLOW;
            decay_b <= msq_pkg::MSQ_DECAY_SLOW;
        end else begin
            if (out_angle_reg[4] ^ fwd_reg) begin // [RULE13]
                decay_a <= msq_pkg::MSQ_DECAY_MIXED;
            end else begin
                decay_a <= msq_pkg::MSQ_DECAY_SLOW;
            end
            if (out_angle_reg[4] ^ !fwd_reg) begin // [RULE13]
                decay_b <= msq_pkg::MSQ_DECAY_MIXED;
            end else begin
                decay_b <= msq_pkg::MSQ_DECAY_SLOW;
            end
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    // Data stand in the cycle after the strobe only
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bus_rdata <= '0;
        end else if (!req.rd) begin
            bus_rdata <= '0;
        end else if (req.addr == `MSQ_OFF_CTRL) begin
            bus_rdata <= {27'h0, ctrl_reg};
        end else if (req.addr == `MSQ_OFF_ANGLE) begin
            bus_rdata <= {26'h0, angle_reg};
        end else if (req.addr == `MSQ_OFF_TBL_ADDR) begin
            bus_rdata <= {26'h0, tbl_addr_reg};
        end else if (req.addr == `MSQ_OFF_TBL_DATA) begin
            bus_rdata <= {18'h0, mem_rdata};
        end else if (req.addr == `MSQ_OFF_STATUS) begin
            bus_rdata <= {28'h0, res_sel, fwd_reg, table_loading};
        end else begin
            bus_rdata <= '0;
        end
    end
endmodule : msq_sequencer

//--- pkg/msq_regs.svh
// Contract
// RULE1: Sixty-four entry table indexed by angle number
// RULE2: Entry holds 6-bit level, direction per phase
// RULE3: One angle unit is a sixteenth microstep
// RULE4: Reset loads sine profile, angle eight
// RULE5: Step pulses move by resolution increment
// RULE6: Resolution defaults to full step
// RULE7: Resolution is OR of pins and config
// RULE8: Serial adds signed 6-bit step change
// RULE9: Each serial unit moves one position
// RULE10: Host keeps step change within sixteen
// RULE11: Serial step size may change every command
// RULE12: Angle selects level and direction per phase
// RULE13: Decay from table position and motion direction
// RULE14: Levels are fractions of scaled phase maximum
// RULE15: Advance once per step rising edge
// RULE16: Direction high counts up, low down
// RULE17: Direction input ignored under serial control
// RULE18: Code sixty-three means full phase current
// RULE19: Angle wraps modulo sixty-four both ways
// RULE20: Select 0..3 gives increments 16,8,4,1
`ifndef MSQ_REGS_SVH
`define MSQ_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MSQ_OFF_CTRL 8'h00
`define MSQ_OFF_STEP_CHG 8'h04
`define MSQ_OFF_ANGLE 8'h08
`define MSQ_OFF_TBL_ADDR 8'h0c
`define MSQ_OFF_TBL_DATA 8'h10
`define MSQ_OFF_STATUS 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MSQ_CTRL_RES_LO 0
`define MSQ_CTRL_RES_HI 1
`define MSQ_CTRL_MXI_LSB 2
`define MSQ_CTRL_MXI_MSB 3
`define MSQ_CTRL_SERIAL 4
`define MSQ_STAT_LOADING 0
`define MSQ_STAT_FWD 1
`define MSQ_STAT_RES_LSB 2
`define MSQ_STAT_RES_MSB 3

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define MSQ_CTRL_RESET 5'h00
`define MSQ_HOME_ANGLE 6'h08
`define MSQ_TABLE_DEPTH 64
`define MSQ_INC_FULL 7'h10
`define MSQ_INC_HALF 7'h08
`define MSQ_INC_QUARTER 7'h04
`define MSQ_INC_SIXTEENTH 7'h01

`endif

//--- pkg/msq_pkg.sv
package msq_pkg;

    // One phase drive: direction plus DAC level
    typedef struct packed {
        logic dir;
        logic [5:0] dac;
    } msq_phase_t;

    // One table line, phase A in the upper half
    typedef struct packed {
        msq_phase_t a;
        msq_phase_t b;
    } msq_entry_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } msq_bus_req_t;

    typedef enum logic [1:0] {
        MSQ_DECAY_SLOW = 2'b01,
        MSQ_DECAY_MIXED = 2'b10
    } msq_decay_t;

    typedef enum logic [1:0] {
        MSQ_ST_LOAD = 2'b01,
        MSQ_ST_RUN = 2'b10
    } msq_state_t;

endpackage : msq_pkg

//--- core/msq_phase_mem.sv
`timescale 1ns/1ps
// Phase table storage with registered read data
module msq_phase_mem #(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter int DW = 14
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];

    // Write port; contents are filled by the loader after reset
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data registered so drive outputs come from flops
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : msq_phase_mem

//--- core/msq_angle_add.sv
`timescale 1ns/1ps
// Adds a signed delta to the angle and wraps modulo the table size
module msq_angle_add #(
    parameter int AW = 6,
    parameter int DW = 7
) (
    input wire logic [AW-1:0] angle,
    input wire logic signed [DW-1:0] delta,
    output logic [AW-1:0] sum
);
    logic [DW-1:0] wide;

    // Dropping the carry gives the wrap in both directions
    always_comb begin
        wide = DW'({1'b0, angle}) + delta;
        sum = wide[AW-1:0]; // [RULE19]
    end
endmodule : msq_angle_add

//--- sim/msq_seq_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// Sequencer port checks
// ----------------------------------------
module msq_seq_asserts (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic step_res_sel_lo,
    input wire logic step_res_sel_hi,
    input wire msq_pkg::msq_phase_t phase_a,
    input wire msq_pkg::msq_phase_t phase_b,
    input wire msq_pkg::msq_decay_t decay_a,
    input wire msq_pkg::msq_decay_t decay_b,
    input wire logic [1:0] phase_max_scale,
    input wire logic table_loading
);
    logic [4:0] ctrl_reg;

    // Shadow of CTRL, so the checks know mode and resolution
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= 5'h00;
        end else if (bus_wr && bus_addr == 8'h00) begin
            ctrl_reg <= bus_wdata[4:0];
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Table load runs after every release of reset
    load_span_a: assert property ($fell(reset) |->
        table_loading [*8])
        else $error("table load not running after reset");
    load_once_a: assert property (!table_loading |=> !table_loading)
        else $error("table load restarted");
    rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
        else $error("read data outside its cycle");
    stat_load_a: assert property (bus_rd && bus_addr == 8'h14
        |=> bus_rdata[0] == $past(table_loading))
        else $error("status loading bit wrong");
    // Effective resolution is the OR of pins and CTRL bits
    stat_res_a: assert property (bus_rd && bus_addr == 8'h14 |=>
        bus_rdata[3:2] == $past(ctrl_reg[1:0] |
        {step_res_sel_hi, step_res_sel_lo}))
        else $error("status resolution wrong");
    scale_map_a: assert property (bus_wr && bus_addr == 8'h00
        |=> phase_max_scale == $past(bus_wdata[3:2]))
        else $error("max scale not following CTRL");
    // Sine and cosine phases always take opposite decay
    decay_pair_a: assert property (!table_loading &&
        !$past(table_loading, 4) |-> decay_a != decay_b)
        else $error("both phases on same decay");
    serial_hold_a: assert property ((ctrl_reg[4] && !bus_wr &&
        !table_loading) [*4] |-> $stable(phase_a) && $stable(phase_b))
        else $error("phase moved in serial mode without command");
    // A full step always crosses a quadrant, so some phase changes
    full_step_a: assert property ($rose(step_in) && !ctrl_reg[4] &&
        ctrl_reg[1:0] == 2'b00 && !step_res_sel_lo && !step_res_sel_hi &&
        !table_loading && !$past(table_loading, 4) |->
        ##3 {phase_a, phase_b} != $past({phase_a, phase_b}, 3))
        else $error("full step left phases unchanged");

    cover property ($rose(step_in) && !ctrl_reg[4]);
    cover property (bus_wr && bus_addr == 8'h04 && ctrl_reg[4]);
    cover property ($fell(table_loading));
endmodule : msq_seq_asserts

bind msq_sequencer msq_seq_asserts msq_seq_asserts_i (
    .sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .step_in(step_in), .dir_in(dir_in),
    .step_res_sel_lo(step_res_sel_lo), .step_res_sel_hi(step_res_sel_hi),
    .phase_a(phase_a), .phase_b(phase_b), .decay_a(decay_a),
    .decay_b(decay_b), .phase_max_scale(phase_max_scale),
    .table_loading(table_loading)
);

//--- sim/msq_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host driving the step and direction pins
// ----------------------------------------
module msq_host_model #(
    parameter int HOLD = 2
) (
    input wire logic sys_clk,
    output logic step_in,
    output logic dir_in
);
    // Pins idle low until the first command
    initial begin
        step_in = 1'b0;
        dir_in = 1'b0;
    end

    // One pulse per step, low long enough between edges
    task automatic pulse(input logic up);
        @(posedge sys_clk);
        dir_in <= up; // set a cycle ahead of the edge
        @(posedge sys_clk);
        step_in <= 1'b1;
        repeat (HOLD) @(posedge sys_clk);
        step_in <= 1'b0;
        repeat (HOLD + 2) @(posedge sys_clk);
    endtask : pulse
endmodule : msq_host_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic sys_clk, reset, bus_wr, bus_rd, step_in, dir_in, res_lo, res_hi;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata, rd_val;
    msq_pkg::msq_phase_t phase_a, phase_b;
    msq_pkg::msq_decay_t decay_a, decay_b;
    logic [1:0] phase_max_scale;
    logic table_loading;
    logic [5:0] angle_exp;
    int bad_count, n_checks;

    msq_sequencer msq_sequencer_i (.sys_clk(sys_clk), .reset(reset),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .step_in(step_in),
        .dir_in(dir_in), .step_res_sel_lo(res_lo), .step_res_sel_hi(res_hi),
        .phase_a(phase_a), .phase_b(phase_b), .decay_a(decay_a),
        .decay_b(decay_b), .phase_max_scale(phase_max_scale),
        .table_loading(table_loading));
    msq_host_model #(.HOLD(2)) msq_host_model_i (.sys_clk(sys_clk),
        .step_in(step_in), .dir_in(dir_in));

    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask : bus_write

    // Read data stand only in the cycle after the strobe
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask : bus_read

    task automatic chk_angle();
        bus_read(8'h08, rd_val);
        chk(rd_val, {26'h0, angle_exp});
    endtask : chk_angle

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset, count the load span, then check the home position
    task automatic t_reset();
        int n;
        n = 0;
        reset <= 1'b1;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        res_lo <= 1'b0;
        res_hi <= 1'b0;
        angle_exp = 6'h08;
        #1;
        while (table_loading === 1'b1 && n < 200) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
        chk(32'(n), 32'h40);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({25'h0, phase_a}, 32'h6d);
        chk({25'h0, phase_b}, 32'h6d);
        chk({30'h0, decay_a}, {30'h0, msq_pkg::MSQ_DECAY_MIXED});
        chk({30'h0, decay_b}, {30'h0, msq_pkg::MSQ_DECAY_SLOW});
        chk_angle();
        bus_read(8'h00, rd_val);
        chk(rd_val, 32'h0);
        bus_read(8'h14, rd_val);
        chk(rd_val, 32'h2);
        $display("t_reset done");
    endtask : t_reset

    // Every resolution, split between pins and CTRL, both directions
    task automatic t_steps();
        logic [5:0] inc;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            // Each select bit comes once from a pin, once from CTRL
            res_lo <= (i == 1);
            res_hi <= (i == 3);
            bus_write(8'h00, {30'h0, (i == 2), (i == 3)});
            bus_read(8'h14, rd_val);
            chk({30'h0, rd_val[3:2]}, 32'(i));
            inc = (i == 0) ? 6'h10 : (i == 1) ? 6'h08 :
                (i == 2) ? 6'h04 : 6'h01;
            for (int k = 0; k < 3; k++) begin
                msq_host_model_i.pulse(k != 0);
                angle_exp = (k != 0) ? angle_exp + inc : angle_exp - inc;
                chk_angle();
            end
        end
        @(posedge sys_clk);
        res_lo <= 1'b0;
        res_hi <= 1'b0;
        $display("t_steps done");
    endtask : t_steps

    // Signed step changes, ignored outside serial mode
    task automatic t_serial();
        logic [5:0] d [6];
        d = '{6'h05, 6'h10, 6'h30, 6'h01, 6'h3f, 6'h00}; // within 16
        bus_write(8'h00, 32'h0);
        bus_write(8'h04, 32'h05);
        chk_angle();
        bus_write(8'h00, 32'h10);
        msq_host_model_i.pulse(1'b1);
        chk_angle();
        for (int i = 0; i < 6; i++) begin
            bus_write(8'h04, {26'h0, d[i]});
            angle_exp = angle_exp + d[i];
            chk_angle();
        end
        // Last move was backward at 42: sine falling, cosine rising
        chk({30'h0, decay_a}, {30'h0, msq_pkg::MSQ_DECAY_SLOW});
        chk({30'h0, decay_b}, {30'h0, msq_pkg::MSQ_DECAY_MIXED});
        bus_read(8'h14, rd_val);
        chk(rd_val, 32'h0);
        $display("t_serial done");
    endtask : t_serial

    // Max scale field, CTRL readback, ignored and unmapped places
    task automatic t_scale();
        for (int i = 0; i < 4; i++) begin
            bus_write(8'h00, {28'h0, i[1:0], 2'b00});
            #1;
            chk({30'h0, phase_max_scale}, 32'(i));
            bus_read(8'h00, rd_val);
            chk(rd_val, {28'h0, i[1:0], 2'b00});
        end
        bus_write(8'h08, 32'h3f);
        chk_angle();
        bus_read(8'h40, rd_val);
        chk(rd_val, 32'h0);
        $display("t_scale done");
    endtask : t_scale

    // Software line at the current angle drives both phases
    task automatic t_table();
        bus_write(8'h00, 32'h10);
        bus_write(8'h0c, {26'h0, angle_exp});
        bus_write(8'h10, 32'h3f85);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({25'h0, phase_a}, 32'h7f);
        chk({25'h0, phase_b}, 32'h05);
        bus_read(8'h10, rd_val);
        chk(rd_val, 32'h3f85);
        bus_read(8'h0c, rd_val);
        chk(rd_val, {26'h0, angle_exp + 6'h01});
        $display("t_table done");
    endtask : t_table

    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        close_out();
    end

    // Main sequence, ending with a mid-run reset that reloads the table
    initial begin
        reset = 1'b1;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        res_lo = 1'b0;
        res_hi = 1'b0;
        bad_count = 0;
        n_checks = 0;
        t_reset();
        t_steps();
        t_serial();
        t_scale();
        t_table();
        t_reset();
        close_out();
    end
endmodule : tb_top
